//--- rtl/adc_chan_pkg.sv
// Package: register map, field layout and codes for the converter channel control block
package adc_chan_pkg;

  // Byte addresses on the register bus (one aligned word each)
  localparam logic [7:0] OFF_GLOBAL_CTRL   = 8'h00; // Global control, launch bits 5:2
  localparam logic [7:0] OFF_RESULT_LOW    = 8'h10; // Low result byte
  localparam logic [7:0] OFF_RESULT_HIGH   = 8'h14; // High result byte
  localparam logic [7:0] OFF_COMPARE_LOW   = 8'h18; // Low compare byte
  localparam logic [7:0] OFF_COMPARE_HIGH  = 8'h1C; // High compare byte
  localparam logic [7:0] OFF_CHAN_CTRL     = 8'h20; // Channel control
  localparam logic [7:0] OFF_INPUT_SELECT  = 8'h24; // Input select
  localparam logic [7:0] OFF_IRQ_CTRL      = 8'h28; // Interrupt control
  localparam logic [7:0] OFF_IRQ_FLAGS     = 8'h2C; // Interrupt flags
  localparam logic [7:0] OFF_CONV_CFG      = 8'h30; // Signedness and result format

  // Field positions
  localparam int LAUNCH_BIT      = 7; // Start bit in channel control
  localparam int GLOBAL_LAUNCH_LSB = 2; // Launch bits 5:2 in global control
  localparam int GAIN_LSB        = 2; // Gain code bits 4:2
  localparam int POS_LSB         = 3; // Positive select bits 6:3
  localparam int COND_LSB        = 2; // Interrupt condition bits 3:2

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Register read masks (reserved bits read as zero)
  localparam logic [7:0] MASK_CHAN_CTRL  = 8'h9F;
  localparam logic [7:0] MASK_INPUT_SEL  = 8'h7F;
  localparam logic [7:0] MASK_IRQ_CTRL   = 8'h0F;
  localparam logic [7:0] MASK_CONV_CFG   = 8'h03;

  // Input kind codes
  localparam logic [1:0] KIND_INTERNAL  = 2'h0;
  localparam logic [1:0] KIND_SINGLE    = 2'h1;
  localparam logic [1:0] KIND_DIFF      = 2'h2;
  localparam logic [1:0] KIND_DIFF_GAIN = 2'h3;

  // Interrupt condition codes
  localparam logic [1:0] COND_COMPLETE = 2'h0;
  localparam logic [1:0] COND_BELOW    = 2'h1;
  localparam logic [1:0] COND_ABOVE    = 2'h3;

  // Analog route kinds driven to the front end
  typedef enum logic [2:0]
  {
    ROUTE_PIN,
    ROUTE_TEMP,
    ROUTE_BANDGAP,
    ROUTE_SCALED_SUPPLY,
    ROUTE_DAC,
    ROUTE_PAD_GND,
    ROUTE_INT_GND,
    ROUTE_NONE
  } route_t;

  // Bus response codes
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- rtl/adc_channel_config_compare.sv
// Register-level control of one converter channel: compare, launch, gain, input routing, flag
//
// Function
// - Left-adjusted 12-bit: low nibble bits 7:4, rest zero
// - 16-bit compare value over high/low bytes
// - Low compare byte at 0x18, RW, resets zero
// - Start bit launches, self-clears, re-set ignored
// - Start bit aliases global launch bit
// - Gain code 000..110 doubling, 111 half
// - Unsigned mode: internal, single-ended, others reserved
// - Signed mode: internal, single, differential, diff gain
// - Input kind change may flush pipeline data
// - Internal positive: temp, bandgap, supply/10, DAC
// - Single/differential: positive code picks pin
// - Diff gain: pins 0..7, top bit reserved
// - Negative select used only for differential
// - Diff no gain: pins 0..3, pad, internal ground
// - Diff gain: pins 4..7, internal, pad ground
// - Condition: complete, below, above; 10 reserved
// - Nonzero level with flag set requests interrupt
// - Flag sets on event, clears on service or one
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/1ns

module adc_channel_config_compare #(
  parameter int CHANNEL = 0 // Which global launch bit this channel owns (0..3)
)(
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_n,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Conversion pipeline side
  input  wire logic        conv_started,
  input  wire logic        conv_done,
  input  wire logic [11:0] conv_result,
  input  wire logic        irq_serviced,
  output logic             conv_launch,
  output logic             pipeline_flush,
  // Analog front-end setup
  output logic [2:0]       gain_code,
  output logic [7:0]       gain_factor_x2,
  output logic             gain_stage_used,
  output adc_chan_pkg::route_t pos_route,
  output logic [3:0]       pos_pin,
  output adc_chan_pkg::route_t neg_route,
  output logic [3:0]       neg_pin,
  output logic             select_reserved,
  // Interrupt request
  output logic             irq_request,
  output logic [1:0]       irq_level
);

  // All state of the block
  typedef struct packed {
    logic        awready;      // Write address taken, waiting for data
    logic [7:0]  awaddr;       // Held write address
    logic        wfull;        // Write data taken
    logic [31:0] wdata;        // Held write data
    logic [3:0]  wstrb;        // Held strobes
    logic        bvalid;       // Write response pending
    logic [1:0]  bresp;        // Write response code
    logic        rvalid;       // Read data pending
    logic [31:0] rdata;        // Read data
    logic [1:0]  rresp;        // Read response code
    logic        launch;       // Start bit, shared with global view
    logic [2:0]  gain;         // Gain code
    logic [1:0]  kind;         // Input kind
    logic [3:0]  pos_sel;      // Positive select
    logic [2:0]  neg_sel;      // Negative select
    logic [15:0] threshold;    // Compare value
    logic [1:0]  cond;         // Interrupt condition
    logic [1:0]  level;        // Interrupt level
    logic        flag;         // Channel flag
    logic        signed_mode;  // Conversion signedness
    logic        left_adjust;  // Result format
    logic [11:0] result;       // Last result
    logic        flush;        // Pipeline flush pulse
  } state_t;

  state_t st;       // Registered state
  state_t next_st;  // Next state

  logic aw_take;  // Address accepted this cycle
  logic w_take;   // Data accepted this cycle

  // Signed or unsigned comparison of result against threshold
  function automatic logic below_threshold(input logic [15:0] res, input logic [15:0] thr, input logic sgn);
    if (sgn)
      below_threshold = $signed(res) < $signed(thr);
    else
      below_threshold = res < thr;
  endfunction

  // Low result byte as seen by software
  function automatic logic [7:0] low_byte(input logic [11:0] res, input logic left);
    if (left)
      low_byte = {res[3:0], 4'h0};
    else
      low_byte = res[7:0];
  endfunction

  // 16-bit view of a 12-bit result, sign-extended in signed mode
  logic [15:0] result_wide;
  assign result_wide = st.signed_mode ? {{4{st.result[11]}}, st.result} : {4'h0, st.result};

  // The two compare outcomes for the incoming result
  logic [15:0] incoming_wide;
  logic        is_below;
  logic        is_above;
  assign incoming_wide = st.signed_mode ? {{4{conv_result[11]}}, conv_result} : {4'h0, conv_result};
  assign is_below = below_threshold(incoming_wide, st.threshold, st.signed_mode);
  assign is_above = below_threshold(st.threshold, incoming_wide, st.signed_mode);

  // Handshake outputs are combinational on held slots
  assign s_axi_awready = ~st.awready & ~st.bvalid;
  assign s_axi_wready  = ~st.wfull & ~st.bvalid;
  assign s_axi_arready = ~st.rvalid; // One read answer at a time
  assign aw_take       = s_axi_awvalid & s_axi_awready;
  assign w_take        = s_axi_wvalid & s_axi_wready;

  // Next-state logic: bus slave, registers, launch and flag
  always_comb
  begin
    logic       do_write;   // Both halves of a write present
    logic [7:0] wb;         // Byte lane 0 of the write
    logic       event_hit;  // Flag-setting event
    logic [7:0] rbyte;      // Read byte
    logic       rhit;       // Read address is mapped
    logic       whit;       // Write address is mapped
    state_t     held;       // State before a write lands
    do_write  = 1'b0;
    wb        = 8'h00;
    event_hit = 1'b0;
    rbyte     = 8'h00;
    rhit      = 1'b1;
    whit      = 1'b1;
    held      = st;
    next_st   = st;
    next_st.flush = 1'b0;

    // Capture write address and data in either order
    if (aw_take)
    begin
      next_st.awready = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (w_take)
    begin
      next_st.wfull = 1'b1;
      next_st.wdata = s_axi_wdata;
      next_st.wstrb = s_axi_wstrb;
    end

    // Conversion begins: hardware clears the start bit
    if (conv_started)
      next_st.launch = 1'b0;

    // Completed conversion stores result and may set the flag
    if (conv_done)
    begin
      next_st.result = conv_result;
      case (st.cond)
        adc_chan_pkg::COND_COMPLETE: event_hit = 1'b1;
        adc_chan_pkg::COND_BELOW:    event_hit = is_below;
        adc_chan_pkg::COND_ABOVE:    event_hit = is_above;
        default:         event_hit = 1'b0; // Reserved code never flags
      endcase
    end

    // Service of the interrupt clears the flag
    if (irq_serviced)
      next_st.flag = 1'b0;

    // Perform the write once both halves are held
    do_write = st.awready & st.wfull;
    wb       = st.wdata[7:0];
    if (do_write)
    begin
      next_st.awready = 1'b0;
      next_st.wfull   = 1'b0;
      next_st.bvalid  = 1'b1;
      // Snapshot: a write with lane 0 off changes no register
      held = next_st;
      begin
        case (st.awaddr)
          adc_chan_pkg::OFF_GLOBAL_CTRL:
            if (wb[adc_chan_pkg::GLOBAL_LAUNCH_LSB + CHANNEL] && !st.launch)
              next_st.launch = 1'b1;
          adc_chan_pkg::OFF_COMPARE_LOW:
            next_st.threshold[7:0] = wb;
          adc_chan_pkg::OFF_COMPARE_HIGH:
            next_st.threshold[15:8] = wb;
          adc_chan_pkg::OFF_CHAN_CTRL:
          begin
            // A one while set does nothing, even as a conversion begins
            if (wb[adc_chan_pkg::LAUNCH_BIT] && !st.launch)
              next_st.launch = 1'b1;
            next_st.gain = wb[adc_chan_pkg::GAIN_LSB +: 3];
            next_st.kind = wb[1:0];
            // A change of input kind flushes data in flight
            if (wb[1:0] != st.kind)
              next_st.flush = 1'b1;
          end
          adc_chan_pkg::OFF_INPUT_SELECT:
          begin
            next_st.pos_sel = wb[adc_chan_pkg::POS_LSB +: 4];
            next_st.neg_sel = wb[2:0];
          end
          adc_chan_pkg::OFF_IRQ_CTRL:
          begin
            next_st.cond  = wb[adc_chan_pkg::COND_LSB +: 2];
            next_st.level = wb[1:0];
          end
          adc_chan_pkg::OFF_IRQ_FLAGS:
            if (wb[0])
              next_st.flag = 1'b0;
          adc_chan_pkg::OFF_CONV_CFG:
          begin
            next_st.signed_mode = wb[0];
            next_st.left_adjust = wb[1];
          end
          adc_chan_pkg::OFF_RESULT_LOW, adc_chan_pkg::OFF_RESULT_HIGH:
            whit = 1'b1; // Read-only, write ignored
          default:
            whit = 1'b0;
        endcase
      end
      if (!st.wstrb[0])
        next_st = held;
      next_st.bresp = whit ? adc_chan_pkg::RESP_OKAY : adc_chan_pkg::RESP_SLVERR;
    end

    // Set wins over any clear in the same cycle
    if (event_hit)
      next_st.flag = 1'b1;

    // Write response handshake
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // Read: decode and hold until taken
    if (s_axi_arvalid && !st.rvalid)
    begin
      case (s_axi_araddr)
        adc_chan_pkg::OFF_GLOBAL_CTRL:
          rbyte = 8'(st.launch) << (adc_chan_pkg::GLOBAL_LAUNCH_LSB + CHANNEL);
        adc_chan_pkg::OFF_RESULT_LOW:   rbyte = low_byte(st.result, st.left_adjust);
        adc_chan_pkg::OFF_RESULT_HIGH:
          rbyte = st.left_adjust ? st.result[11:4] : result_wide[15:8];
        adc_chan_pkg::OFF_COMPARE_LOW:  rbyte = st.threshold[7:0];
        adc_chan_pkg::OFF_COMPARE_HIGH: rbyte = st.threshold[15:8];
        adc_chan_pkg::OFF_CHAN_CTRL:
          rbyte = {st.launch, 2'h0, st.gain, st.kind} & adc_chan_pkg::MASK_CHAN_CTRL;
        adc_chan_pkg::OFF_INPUT_SELECT:
          rbyte = {1'b0, st.pos_sel, st.neg_sel} & adc_chan_pkg::MASK_INPUT_SEL;
        adc_chan_pkg::OFF_IRQ_CTRL:
          rbyte = {4'h0, st.cond, st.level} & adc_chan_pkg::MASK_IRQ_CTRL;
        adc_chan_pkg::OFF_IRQ_FLAGS:    rbyte = {7'h00, st.flag};
        adc_chan_pkg::OFF_CONV_CFG:
          rbyte = {6'h00, st.left_adjust, st.signed_mode} & adc_chan_pkg::MASK_CONV_CFG;
        default:
        begin
          rbyte = 8'h00;
          rhit  = 1'b0; // Unmapped address answers an error
        end
      endcase
      next_st.rvalid = 1'b1;
      next_st.rdata  = {24'h000000, rbyte};
      next_st.rresp  = rhit ? adc_chan_pkg::RESP_OKAY : adc_chan_pkg::RESP_SLVERR;
    end
    else if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    // Synchronous reset to defined values
    if (!rst_n)
    begin
      next_st = '0;
      next_st.threshold = {adc_chan_pkg::RST_BYTE, adc_chan_pkg::RST_BYTE};
    end
  end

  // Register the whole state
  always_ff @(posedge mclk)
  begin
    st <= next_st;
  end

  // Input routing decode for the analog front end
  always_comb
  begin
    logic [1:0] eff_kind; // Kind used for the decode, equal to st.kind in both modes
    eff_kind        = st.kind;
    pos_route       = adc_chan_pkg::ROUTE_NONE;
    pos_pin         = 4'h0;
    neg_route       = adc_chan_pkg::ROUTE_NONE;
    neg_pin         = 4'h0;
    select_reserved = 1'b0;
    // Differential kinds exist only in signed mode
    if (!st.signed_mode && st.kind[1])
      select_reserved = 1'b1;
    case (eff_kind)
      adc_chan_pkg::KIND_INTERNAL:
        case (st.pos_sel)
          4'h0:    pos_route = adc_chan_pkg::ROUTE_TEMP;
          4'h1:    pos_route = adc_chan_pkg::ROUTE_BANDGAP;
          4'h2:    pos_route = adc_chan_pkg::ROUTE_SCALED_SUPPLY;
          4'h3:    pos_route = adc_chan_pkg::ROUTE_DAC;
          default: select_reserved = 1'b1;
        endcase
      adc_chan_pkg::KIND_SINGLE, adc_chan_pkg::KIND_DIFF:
      begin
        pos_route = adc_chan_pkg::ROUTE_PIN;
        pos_pin   = st.pos_sel;
        if (eff_kind == adc_chan_pkg::KIND_DIFF)
        begin
          // Negative side only matters for differential
          case (st.neg_sel)
            3'h0, 3'h1, 3'h2, 3'h3:
            begin
              neg_route = adc_chan_pkg::ROUTE_PIN;
              neg_pin   = {2'h0, st.neg_sel[1:0]};
            end
            3'h5:    neg_route = adc_chan_pkg::ROUTE_PAD_GND;
            3'h7:    neg_route = adc_chan_pkg::ROUTE_INT_GND;
            default: select_reserved = 1'b1;
          endcase
        end
      end
      adc_chan_pkg::KIND_DIFF_GAIN:
      begin
        if (st.pos_sel[3])
          select_reserved = 1'b1;
        else
        begin
          pos_route = adc_chan_pkg::ROUTE_PIN;
          pos_pin   = st.pos_sel;
        end
        case (st.neg_sel)
          3'h0, 3'h1, 3'h2, 3'h3:
          begin
            neg_route = adc_chan_pkg::ROUTE_PIN;
            neg_pin   = {2'h1, st.neg_sel[1:0]};
          end
          3'h4:    neg_route = adc_chan_pkg::ROUTE_INT_GND;
          3'h7:    neg_route = adc_chan_pkg::ROUTE_PAD_GND;
          default: select_reserved = 1'b1;
        endcase
      end
      default: select_reserved = 1'b1;
    endcase
  end

  // Gain: factor in halves so that the 1/2 setting stays integral
  assign gain_code       = st.gain;
  assign gain_factor_x2  = (st.gain == 3'h7) ? 8'h01 : 8'(8'h02 << st.gain);
  // Gain stage only in the differential-with-gain route; elsewhere software must not count on it
  assign gain_stage_used = st.signed_mode && (st.kind == adc_chan_pkg::KIND_DIFF_GAIN);

  // Pipeline side outputs
  assign conv_launch    = st.launch;
  assign pipeline_flush = st.flush;

  // Interrupt request while flag set and level nonzero
  assign irq_request = st.flag && (st.level != 2'h0);
  assign irq_level   = st.level;

  // Bus outputs from the state
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp  = st.bresp;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata  = st.rdata;
  assign s_axi_rresp  = st.rresp;

endmodule // adc_channel_config_compare

//--- verification/adc_chan_monitor.sv
// Concurrent checks on the ports of the converter channel block
`timescale 1ns/1ns
module adc_chan_monitor (
  // Clock and reset
  input wire logic                 mclk,
  input wire logic                 rst_n,
  // Bus handshake
  input wire logic                 s_axi_arready,
  input wire logic                 s_axi_rvalid,
  input wire logic                 s_axi_bvalid,
  // Pipeline and front end
  input wire logic                 conv_started,
  input wire logic                 conv_launch,
  input wire logic                 pipeline_flush,
  input wire logic [2:0]           gain_code,
  input wire logic [7:0]           gain_factor_x2,
  input wire logic                 gain_stage_used,
  input wire adc_chan_pkg::route_t pos_route,
  input wire logic [3:0]           pos_pin,
  input wire logic                 select_reserved,
  // Interrupt request
  input wire logic                 irq_request,
  input wire logic [1:0]           irq_level
);
  // One clock domain
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // Launch falls once the pipeline reports that the conversion began
  property p_launch_clear; conv_launch && conv_started |=> !conv_launch; endproperty
  a_launch_clear: assert property (p_launch_clear) else $error("launch not cleared by start");
  // Launch only rises as a register write lands
  property p_launch_src; $rose(conv_launch) |-> s_axi_bvalid || $past(s_axi_bvalid); endproperty
  a_launch_src: assert property (p_launch_src) else $error("launch rose without a write");
  // Doubling gains for codes 0 to 6
  property p_gain_double; gain_code != 3'h7 |-> gain_factor_x2 == (8'h02 << gain_code); endproperty
  a_gain_double: assert property (p_gain_double) else $error("gain factor wrong");
  // Top code means one half
  property p_gain_half; gain_code == 3'h7 |-> gain_factor_x2 == 7'h01; endproperty
  a_gain_half: assert property (p_gain_half) else $error("half gain wrong");
  // Flush is a single pulse
  property p_flush_pulse; pipeline_flush |=> !pipeline_flush; endproperty
  a_flush_pulse: assert property (p_flush_pulse) else $error("flush longer than a cycle");
  // Flush only follows a register write
  property p_flush_src; pipeline_flush |-> s_axi_bvalid || $past(s_axi_bvalid) || $past(s_axi_bvalid, 2); endproperty
  a_flush_src: assert property (p_flush_src) else $error("flush without a write");
  // Through the gain stage only pins 0 to 7 are routed
  property p_gain_pos; gain_stage_used && pos_route == adc_chan_pkg::ROUTE_PIN |-> !pos_pin[3]; endproperty
  a_gain_pos: assert property (p_gain_pos) else $error("upper pin not flagged reserved");
  // A request always carries a nonzero level
  property p_irq_level; irq_request |-> irq_level != 2'h0; endproperty
  a_irq_level: assert property (p_irq_level) else $error("request at level zero");
  // No new read address while a read answer is pending
  property p_read_block; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_read_block: assert property (p_read_block) else $error("read accepted while pending");
endmodule // adc_chan_monitor

bind adc_channel_config_compare adc_chan_monitor monitor (.mclk, .rst_n, .s_axi_arready, .s_axi_rvalid, .s_axi_bvalid,
  .conv_started, .conv_launch, .pipeline_flush, .gain_code, .gain_factor_x2, .gain_stage_used, .pos_route, .pos_pin,
  .select_reserved, .irq_request, .irq_level);

//--- verification/tb_adc_channel_config_compare.sv
// Register-bus bench for the converter channel block
`timescale 1ns/1ns
module tb_adc_channel_config_compare;
  // Clock, reset and bus master
  logic        mclk = 1'h0, rst_n = 1'h0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
  logic        s_axi_rready = 1'h0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, irq_level;
  // Pipeline and front end
  logic        conv_started = 1'h0, conv_done = 1'h0, irq_serviced = 1'h0;
  logic [11:0] conv_result = 12'h000;
  logic        conv_launch, pipeline_flush, gain_stage_used, select_reserved, irq_request;
  logic [2:0]  gain_code;
  logic [7:0]  gain_factor_x2;
  logic [3:0]  pos_pin, neg_pin;
  adc_chan_pkg::route_t pos_route, neg_route;
  // Short aliases; no_chk marks a route left unchecked
  localparam adc_chan_pkg::route_t pin_sel = adc_chan_pkg::ROUTE_PIN, no_chk = adc_chan_pkg::ROUTE_NONE;
  // Bookkeeping
  int          n_fail = 0, samples_checked = 0, cycles = 0, flushes = 0;

  adc_channel_config_compare #(.CHANNEL(0)) dut (.mclk, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .conv_started, .conv_done, .conv_result, .irq_serviced, .conv_launch, .pipeline_flush, .gain_code,
    .gain_factor_x2, .gain_stage_used, .pos_route, .pos_pin, .neg_route, .neg_pin, .select_reserved,
    .irq_request, .irq_level);

  // 50 MHz clock
  initial
  begin
    forever #10 mclk = ~mclk;
  end

  // Flush count and hang guard at the settled falling edge
  always @(negedge mclk)
  begin
    cycles++;
    if (pipeline_flush === 1'h1) flushes++;
    if (cycles == 6000)
    begin
      n_fail++;
      wrap_up();
    end
  end

  // Verdict and end of run
  task automatic wrap_up();
    if (n_fail == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Bus write; each channel released once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
    logic ta, td, tb;
    tb = 1'h0;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!tb)
    begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      td = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      if (tb) chk("write response", 32'(s_axi_bresp), 32'(er));
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (td) s_axi_wvalid <= 1'h0;
    end
    s_axi_bready <= 1'h0;
  endtask

  // Bus read; data judged only on OKAY
  task automatic rd(input logic [7:0] a, input logic [31:0] ex, input logic [1:0] er = 2'h0);
    logic ta, tr;
    tr = 1'h0;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!tr)
    begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      tr = s_axi_rvalid;
      if (tr) chk($sformatf("read response %h", a), 32'(s_axi_rresp), 32'(er));
      if (tr && er == 2'h0) chk($sformatf("register %h", a), s_axi_rdata, ex);
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 1'h0;
    end
    s_axi_rready <= 1'h0;
  endtask

  // One-cycle pulse on the start or the serviced input
  task automatic strobe(input bit svc);
    @(posedge mclk);
    if (svc) irq_serviced <= 1'h1;
    else conv_started <= 1'h1;
    @(posedge mclk);
    irq_serviced <= 1'h0;
    conv_started <= 1'h0;
    @(negedge mclk);
  endtask

  // Finished conversion with its result
  task automatic conv(input logic [11:0] r);
    @(posedge mclk);
    conv_done <= 1'h1;
    conv_result <= r;
    @(posedge mclk);
    conv_done <= 1'h0;
    @(negedge mclk);
  endtask

  // Set kind and selects, then judge the decoded routing
  task automatic rt(input logic [7:0] ctl, input logic [7:0] mux, input adc_chan_pkg::route_t pr,
                    input logic [3:0] pp, input adc_chan_pkg::route_t nr, input logic [3:0] np, input logic rs);
    wr(8'h20, 32'(ctl));
    wr(8'h24, 32'(mux));
    @(negedge mclk);
    if (pr != no_chk) chk("pos_route", 32'(pos_route), 32'(pr));
    if (pr == pin_sel) chk("pos_pin", 32'(pos_pin), 32'(pp));
    if (nr != no_chk) chk("neg_route", 32'(neg_route), 32'(nr));
    if (nr == pin_sel) chk("neg_pin", 32'(neg_pin), 32'(np));
    chk("select_reserved", 32'(select_reserved), 32'(rs));
  endtask

  // Main sequence
  initial
  begin
    int f;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    // Reset values, storage, unmapped place
    rd(8'h18, 32'h0);
    rd(8'h28, 32'h0);
    rd(8'h2C, 32'h0);
    wr(8'h18, 32'hFFFFFFA5);
    rd(8'h18, 32'hA5);
    wr(8'h1C, 32'h5A);
    rd(8'h1C, 32'h5A);
    wr(8'h3C, 32'h1, 2'h2);
    rd(8'h3C, 32'h0, 2'h2);
    // Every gain code
    for (int g = 0; g < 8; g++)
    begin
      wr(8'h20, 32'(g << 2));
      @(negedge mclk);
      chk("gain_code", 32'(gain_code), 32'(g));
      chk("gain_factor_x2", 32'(gain_factor_x2), (g == 7) ? 32'h1 : 32'(2 << g));
    end
    // Launch, relaunch, start, global alias
    wr(8'h20, 32'h80);
    rd(8'h00, 32'h04);
    wr(8'h20, 32'h80);
    chk("conv_launch", 32'(conv_launch), 32'h1);
    strobe(1'b0);
    rd(8'h20, 32'h0);
    wr(8'h00, 32'h04);
    rd(8'h20, 32'h80);
    strobe(1'b0);
    chk("conv_launch", 32'(conv_launch), 32'h0);
    // Only a kind change flushes
    f = flushes;
    wr(8'h20, 32'h01);
    repeat (3) @(posedge mclk);
    wr(8'h20, 32'h1D);
    repeat (3) @(posedge mclk);
    chk("flush count", 32'(flushes), 32'(f + 1));
    // Routing in signed mode
    wr(8'h30, 32'h1);
    for (int p = 0; p < 5; p++)
      rt(8'h00, 8'(p << 3), (p < 4) ? adc_chan_pkg::route_t'(p + 1) : no_chk, 4'h0, no_chk, 4'h0, p[2]);
    rt(8'h01, 8'h7C, pin_sel, 4'hF, no_chk, 4'h0, 1'h0);
    rt(8'h02, 8'h4B, pin_sel, 4'h9, pin_sel, 4'h3, 1'h0);
    rt(8'h02, 8'h4D, pin_sel, 4'h9, adc_chan_pkg::ROUTE_PAD_GND, 4'h0, 1'h0);
    rt(8'h02, 8'h4F, pin_sel, 4'h9, adc_chan_pkg::ROUTE_INT_GND, 4'h0, 1'h0);
    rt(8'h02, 8'h4C, pin_sel, 4'h9, no_chk, 4'h0, 1'h1);
    rt(8'h03, 8'h38, pin_sel, 4'h7, pin_sel, 4'h4, 1'h0);
    chk("gain_stage_used", 32'(gain_stage_used), 32'h1);
    rt(8'h03, 8'h3C, pin_sel, 4'h7, adc_chan_pkg::ROUTE_INT_GND, 4'h0, 1'h0);
    rt(8'h03, 8'h3F, pin_sel, 4'h7, adc_chan_pkg::ROUTE_PAD_GND, 4'h0, 1'h0);
    rt(8'h03, 8'h3D, pin_sel, 4'h7, no_chk, 4'h0, 1'h1);
    rt(8'h03, 8'h40, no_chk, 4'h0, no_chk, 4'h0, 1'h1);
    // Unsigned: differential reserved, no gain stage
    wr(8'h30, 32'h0);
    chk("gain_stage_used", 32'(gain_stage_used), 32'h0);
    rt(8'h02, 8'h4B, no_chk, 4'h0, no_chk, 4'h0, 1'h1);
    rt(8'h01, 8'h4B, pin_sel, 4'h9, no_chk, 4'h0, 1'h0);
    // Above 0x0100: strictly above sets
    wr(8'h1C, 32'h01);
    wr(8'h18, 32'h00);
    wr(8'h28, 32'h0D);
    conv(12'h101);
    chk("irq_request", 32'(irq_request), 32'h1);
    rd(8'h2C, 32'h1);
    wr(8'h2C, 32'h1);
    rd(8'h2C, 32'h0);
    conv(12'h100);
    rd(8'h2C, 32'h0);
    // Below, then cleared by service
    wr(8'h28, 32'h05);
    conv(12'h0FF);
    rd(8'h2C, 32'h1);
    strobe(1'b1);
    rd(8'h2C, 32'h0);
    // Complete at level 0: flag without request
    wr(8'h28, 32'h00);
    conv(12'h555);
    rd(8'h2C, 32'h1);
    chk("irq_request", 32'(irq_request), 32'h0);
    wr(8'h2C, 32'h1);
    // Signed: 0x800 is negative, so below zero
    wr(8'h30, 32'h1);
    wr(8'h1C, 32'h00);
    wr(8'h28, 32'h07);
    conv(12'h800);
    rd(8'h2C, 32'h1);
    chk("irq_level", 32'(irq_level), 32'h3);
    // Left-adjusted result bytes
    wr(8'h30, 32'h2);
    conv(12'hABC);
    rd(8'h10, 32'hC0);
    rd(8'h14, 32'hAB);
    wrap_up();
  end
endmodule // tb_adc_channel_config_compare
